// ### core/cps_core.sv
`timescale 1ns/100ps
module cps_core (
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	input  wire logic                         cmd_valid,
	input  wire cps_pkg::cps_op_t             cmd_op,
	input  wire cps_pkg::cps_mode_t           cmd_mode,
	input  wire logic [cps_pkg::DATA_W-1:0]   cmd_operand,
	input  wire logic [cps_pkg::IP_W-1:0]     cmd_target,
	input  wire logic [cps_pkg::DATA_W-1:0]   mem_rdata,
	output logic                              cmd_ready,
	output logic [cps_pkg::IP_W-1:0]          instruction_pointer,
	output logic [cps_pkg::DATA_W-1:0]        return_stack_pointer,
	output logic [cps_pkg::DATA_W-1:0]        operand_stack_pointer,
	output logic [cps_pkg::DATA_W-1:0]        accumulator,
	output logic [cps_pkg::DATA_W-1:0]        index_reg,
	output logic                              carry_flag,
	output logic                              zero_flag,
	output logic                              int_enable,
	output logic [cps_pkg::DATA_W-1:0]        mem_addr,
	output logic [cps_pkg::DATA_W-1:0]        mem_wdata,
	output logic                              mem_we,
	output logic                              mem_re
);
	import cps_pkg::*;

	typedef struct packed {
		// Sequencing and command port
		cps_state_t        st;
		logic              ready;

		// Architectural state
		logic [IP_W-1:0]   ip;
		logic [DATA_W-1:0] rsp;
		logic [DATA_W-1:0] osp;
		logic [DATA_W-1:0] acc;
		logic [DATA_W-1:0] idx;
		logic              carry;
		logic              zero;
		logic              ie;

		// Data memory port
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;

		// Held across a multi-cycle command
		logic [DATA_W-1:0] save_lo;
		logic [IP_W-1:0]   jump_to;
		logic              is_iret;
		logic              to_x;
	} cps_regs_t;

	cps_regs_t r;
	cps_regs_t next_r;

	// Operand address for direct and indexed modes
	function automatic logic [DATA_W-1:0] operand_address(
		input cps_mode_t         mode,
		input logic [DATA_W-1:0] konst,
		input logic [DATA_W-1:0] xval
	);
		logic [DATA_W-1:0] sum;
		sum = konst + xval;
		if (mode == MODE_INDEX) begin
			operand_address = sum;
		end else begin
			operand_address = konst;
		end
	endfunction

	// First of the two saved bytes: flags plus page bits of the pointer
	function automatic logic [DATA_W-1:0] save_byte_one(
		input logic [IP_W-1:0] ipv,
		input logic            c,
		input logic            z
	);
		logic [DATA_W-1:0] b;
		b = {2'b00, ipv[IP_W-1:LOW_W]};
		b[SAVE_CARRY_BIT] = c;
		b[SAVE_ZERO_BIT] = z;
		save_byte_one = b;
	endfunction

	// One step of an 8-bit pointer; wraps modulo 256
	function automatic logic [DATA_W-1:0] byte_inc(
		input logic [DATA_W-1:0] v
	);
		byte_inc = v + BYTE_ONE;
	endfunction

	function automatic logic [DATA_W-1:0] byte_dec(
		input logic [DATA_W-1:0] v
	);
		byte_dec = v - BYTE_ONE;
	endfunction

	// Commands whose data end is the index register
	function automatic logic to_index(
		input cps_op_t op
	);
		to_index = (op == OP_PUSH_X) || (op == OP_POP_X) || (op == OP_LOAD_X);
	endfunction

	// Loaded byte lands in the index register or the accumulator
	function automatic cps_regs_t put_loaded(
		input cps_regs_t         s,
		input logic [DATA_W-1:0] v
	);
		put_loaded = s;
		if (s.to_x) begin
			put_loaded.idx = v;
		end else begin
			put_loaded.acc = v;
		end
	endfunction

	always_comb begin
		next_r = r;
		next_r.we = 1'b0;
		next_r.re = 1'b0;
		case (r.st)
			ST_IDLE: begin
				if (cmd_valid) begin
					case (cmd_op)
						OP_FLAGS: begin
							next_r.carry = cmd_operand[1];
							next_r.zero = cmd_operand[0];
						end

						OP_STEP: begin
							next_r.ip[LOW_W-1:0] = byte_inc(r.ip[LOW_W-1:0]);
						end

						OP_PAGE: begin
							next_r.ip[IP_W-1:LOW_W] = r.ip[IP_W-1:LOW_W] + 6'h01;
						end

						// First save byte goes out now, the second from ST_SAVE2
						OP_CALL, OP_INTR: begin
							if (cmd_op == OP_INTR) begin
								next_r.ie = 1'b0;
							end
							next_r.addr = r.rsp;
							next_r.wdata = save_byte_one(r.ip, r.carry, r.zero);
							next_r.we = 1'b1;
							next_r.rsp = byte_inc(r.rsp);
							next_r.save_lo = r.ip[LOW_W-1:0];
							next_r.jump_to = cmd_target;
							next_r.ready = 1'b0;
							next_r.st = ST_SAVE2;
						end

						// The low pointer byte sits on top, so it comes back first
						OP_IRET, OP_SRET: begin
							next_r.rsp = byte_dec(r.rsp);
							next_r.addr = byte_dec(r.rsp);
							next_r.re = 1'b1;
							next_r.is_iret = (cmd_op == OP_IRET);
							next_r.ready = 1'b0;
							next_r.st = ST_RLO_WT;
						end

						OP_PUSH_A, OP_PUSH_X: begin
							next_r.osp = byte_dec(r.osp);
							next_r.addr = byte_dec(r.osp);
							next_r.wdata = to_index(cmd_op) ? r.idx : r.acc;
							next_r.we = 1'b1;
						end

						OP_POP_A, OP_POP_X: begin
							next_r.addr = r.osp;
							next_r.re = 1'b1;
							next_r.to_x = to_index(cmd_op);
							next_r.ready = 1'b0;
							next_r.st = ST_POP_WT;
						end

						OP_LOAD_A, OP_LOAD_X: begin
							if (cmd_mode == MODE_IMM) begin
								if (to_index(cmd_op)) begin
									next_r.idx = cmd_operand;
								end else begin
									next_r.acc = cmd_operand;
								end
							end else begin
								next_r.addr = operand_address(cmd_mode, cmd_operand, r.idx);
								next_r.re = 1'b1;
								next_r.to_x = to_index(cmd_op);
								next_r.ready = 1'b0;
								next_r.st = ST_LD_WT;
							end
						end

						// An immediate store names no address, so it is dropped
						OP_STORE_A: begin
							if (cmd_mode != MODE_IMM) begin
								next_r.addr = operand_address(cmd_mode, cmd_operand, r.idx);
								next_r.wdata = r.acc;
								next_r.we = 1'b1;
							end
						end

						OP_RSP_A: begin
							next_r.rsp = r.acc;
						end

						OP_SWAP_AX: begin
							next_r.acc = r.idx;
							next_r.idx = r.acc;
						end

						default: begin
							next_r.ready = 1'b1;
						end
					endcase
				end
			end

			// Second save byte and the jump land in the same cycle
			ST_SAVE2: begin
				next_r.addr = r.rsp;
				next_r.wdata = r.save_lo;
				next_r.we = 1'b1;
				next_r.rsp = byte_inc(r.rsp);
				next_r.ip = r.jump_to;
				next_r.ready = 1'b1;
				next_r.st = ST_IDLE;
			end

			// Read data stands one cycle after the strobe
			ST_RLO_WT: begin
				next_r.st = ST_RLO_CAP;
			end

			ST_RLO_CAP: begin
				next_r.save_lo = mem_rdata;
				next_r.rsp = byte_dec(r.rsp);
				next_r.addr = byte_dec(r.rsp);
				next_r.re = 1'b1;
				next_r.st = ST_RHI_WT;
			end

			ST_RHI_WT: begin
				next_r.st = ST_RHI_CAP;
			end

			// Flags and enable come back only on an interrupt return
			ST_RHI_CAP: begin
				next_r.ip = {mem_rdata[PAGE_W-1:0], r.save_lo};
				if (r.is_iret) begin
					next_r.carry = mem_rdata[SAVE_CARRY_BIT];
					next_r.zero = mem_rdata[SAVE_ZERO_BIT];
					next_r.ie = 1'b1;
				end
				next_r.ready = 1'b1;
				next_r.st = ST_IDLE;
			end

			ST_POP_WT: begin
				next_r.st = ST_POP_CAP;
			end

			ST_POP_CAP: begin
				next_r = put_loaded(next_r, mem_rdata);
				next_r.osp = byte_inc(r.osp);
				next_r.ready = 1'b1;
				next_r.st = ST_IDLE;
			end

			ST_LD_WT: begin
				next_r.st = ST_LD_CAP;
			end

			ST_LD_CAP: begin
				next_r = put_loaded(next_r, mem_rdata);
				next_r.ready = 1'b1;
				next_r.st = ST_IDLE;
			end

			// Unused state codes fall back to an open command port
			default: begin
				next_r.ready = 1'b1;
				next_r.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r.st <= ST_IDLE;
			r.ready <= 1'b1;
			r.ip <= IP_RESET;
			r.rsp <= RSP_RESET;
			r.osp <= OSP_RESET;
			r.acc <= '0;
			r.idx <= '0;
			r.carry <= 1'b0;
			r.zero <= 1'b0;
			r.ie <= 1'b0;
			r.addr <= '0;
			r.wdata <= '0;
			r.we <= 1'b0;
			r.re <= 1'b0;
			r.save_lo <= '0;
			r.jump_to <= IP_RESET;
			r.is_iret <= 1'b0;
			r.to_x <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign cmd_ready = r.ready;
	assign instruction_pointer = r.ip;
	assign return_stack_pointer = r.rsp;
	assign operand_stack_pointer = r.osp;
	assign accumulator = r.acc;
	assign index_reg = r.idx;
	assign carry_flag = r.carry;
	assign zero_flag = r.zero;
	assign int_enable = r.ie;
	assign mem_addr = r.addr;
	assign mem_wdata = r.wdata;
	assign mem_we = r.we;
	assign mem_re = r.re;

endmodule

// ### core/cps_pkg.sv
package cps_pkg;

	localparam int IP_W   = 14;
	localparam int PAGE_W = 6;
	localparam int LOW_W  = 8;
	localparam int DATA_W = 8;

	localparam logic [IP_W-1:0]   IP_RESET  = 14'h0000;
	localparam logic [DATA_W-1:0] RSP_RESET = 8'h00;
	localparam logic [DATA_W-1:0] OSP_RESET = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;

	// First saved byte: {carry, zero, ip[13:8]}; second saved byte: ip[7:0]
	localparam int SAVE_CARRY_BIT = 7;
	localparam int SAVE_ZERO_BIT  = 6;

	typedef enum logic [3:0] {
		OP_FLAGS   = 4'h0,
		OP_STEP    = 4'h1,
		OP_PAGE    = 4'h2,
		OP_CALL    = 4'h3,
		OP_INTR    = 4'h4,
		OP_IRET    = 4'h5,
		OP_SRET    = 4'h6,
		OP_PUSH_A  = 4'h7,
		OP_PUSH_X  = 4'h8,
		OP_POP_A   = 4'h9,
		OP_POP_X   = 4'ha,
		OP_LOAD_A  = 4'hb,
		OP_LOAD_X  = 4'hc,
		OP_STORE_A = 4'hd,
		OP_RSP_A   = 4'he,
		OP_SWAP_AX = 4'hf
	} cps_op_t;

	typedef enum logic [1:0] {
		MODE_IMM   = 2'h0,
		MODE_DIR   = 2'h1,
		MODE_INDEX = 2'h2
	} cps_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_SAVE2   = 4'h1,
		ST_RLO_WT  = 4'h2,
		ST_RLO_CAP = 4'h3,
		ST_RHI_WT  = 4'h4,
		ST_RHI_CAP = 4'h5,
		ST_POP_WT  = 4'h6,
		ST_POP_CAP = 4'h7,
		ST_LD_WT   = 4'h8,
		ST_LD_CAP  = 4'h9
	} cps_state_t;

endpackage

// ### dv/cps_core_checker.sv
`timescale 1ns/100ps
module cps_core_checker (
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	cmd_valid,
	input wire logic	cmd_ready,
	input wire cps_pkg::cps_op_t	cmd_op,
	input wire logic [13:0]	instruction_pointer,
	input wire logic [7:0]	return_stack_pointer,
	input wire logic [7:0]	operand_stack_pointer,
	input wire logic	carry_flag,
	input wire logic	zero_flag,
	input wire logic	int_enable,
	input wire logic [7:0]	mem_addr,
	input wire logic [7:0]	mem_wdata,
	input wire logic	mem_we,
	input wire logic	mem_re
);
	import cps_pkg::*;
	wire [13:0] ip = instruction_pointer;
	wire [7:0] rsp = return_stack_pointer;
	wire [7:0] osp = operand_stack_pointer;
	wire tk = cmd_valid && cmd_ready;
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	reset_clr_a: assert property (disable iff (1'b0)
		!reset_n |=> ip == 14'h0000 && rsp == 8'h00 && osp == 8'h00)
		else $error("reset state wrong");
	step_low_a: assert property (
		tk && cmd_op == OP_STEP |=> ip[7:0] == $past(ip[7:0]) + 8'h01 && $stable(ip[13:8]))
		else $error("step wrong");
	page_step_a: assert property (
		tk && cmd_op == OP_PAGE |=> ip[13:8] == $past(ip[13:8]) + 6'h01 && $stable(ip[7:0]))
		else $error("page step wrong");
	push_pre_a: assert property (
		tk && cmd_op == OP_PUSH_A |=> mem_we && mem_addr == $past(osp) - 8'h01 && osp == mem_addr)
		else $error("push order wrong");
	pop_post_a: assert property (
		tk && cmd_op == OP_POP_A |=> mem_re && mem_addr == osp ##2 osp == $past(osp, 3) + 8'h01)
		else $error("pop order wrong");
	call_save_a: assert property (
		tk && (cmd_op == OP_CALL || cmd_op == OP_INTR) |=> mem_we && mem_addr == $past(rsp)
		&& mem_wdata == {$past(carry_flag), $past(zero_flag), $past(ip[13:8])}
		##1 mem_we && mem_wdata == $past(ip[7:0], 2) && rsp == $past(rsp, 2) + 8'h02)
		else $error("save sequence wrong");
	iret_seq_a: assert property (
		tk && cmd_op == OP_IRET |=> mem_re && mem_addr == $past(rsp) - 8'h01
		##2 mem_re && mem_addr == $past(rsp, 3) - 8'h02 ##2 int_enable)
		else $error("interrupt return wrong");
	sret_keep_a: assert property (
		tk && cmd_op == OP_SRET |=> ($stable(carry_flag) && $stable(zero_flag))[*5]
		##0 rsp == $past(rsp, 5) - 8'h02)
		else $error("subroutine exit wrong");
	intr_mask_a: assert property (
		tk && cmd_op == OP_INTR |=> !int_enable && mem_we && !cmd_ready)
		else $error("interrupt mask wrong");
	cover property (tk && cmd_op == OP_CALL);
	cover property (tk && cmd_op == OP_PUSH_A);
	cover property (tk && cmd_op == OP_IRET);
	cover property (tk && cmd_op == OP_POP_A);
endmodule

bind cps_core cps_core_checker u_chk (.clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_op,
	.instruction_pointer, .return_stack_pointer, .operand_stack_pointer, .carry_flag,
	.zero_flag, .int_enable, .mem_addr, .mem_wdata, .mem_we, .mem_re);

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import cps_pkg::*;
	logic	clk, reset_n, cmd_valid, cmd_ready, cf, zf, ie, mem_we, mem_re;
	cps_op_t	cmd_op;
	cps_mode_t	cmd_mode;
	logic [7:0]	cmd_operand, mem_rdata, rsp, osp, acc, idx, mem_addr, mem_wdata;
	logic [13:0]	cmd_target, ip;
	logic [7:0]	ram [256];
	int	errors, checks, cycles;
	cps_core DUT (.clk, .reset_n, .cmd_valid, .cmd_op, .cmd_mode, .cmd_operand, .cmd_target,
		.mem_rdata, .cmd_ready, .instruction_pointer(ip), .return_stack_pointer(rsp),
		.operand_stack_pointer(osp), .accumulator(acc), .index_reg(idx), .carry_flag(cf),
		.zero_flag(zf), .int_enable(ie), .mem_addr, .mem_wdata, .mem_we, .mem_re);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Data memory: read data follows the edge that samples the read strobe
	always @(posedge clk) begin
		cycles++;
		if (mem_we) ram[mem_addr] <= mem_wdata;
		if (mem_re) mem_rdata <= ram[mem_addr];
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(cps_op_t o, logic [7:0] d = 8'h00, cps_mode_t m = MODE_IMM,
		logic [13:0] t = 14'h0000);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= o;
		cmd_mode <= m;
		cmd_operand <= d;
		cmd_target <= t;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic conclude();
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_reset();
		chk(ip, 14'h0000);
		chk(rsp, 8'h00);
		chk(osp, 8'h00);
	endtask
	task automatic t_pointer();
		repeat (255) cmd(OP_STEP);
		chk(ip, 14'h00ff);
		cmd(OP_STEP);
		chk(ip, 14'h0000);
		cmd(OP_PAGE);
		chk(ip, 14'h0100);
	endtask
	task automatic t_stack();
		cmd(OP_LOAD_A, 8'h5a);
		chk(acc, 8'h5a);
		cmd(OP_PUSH_A);
		chk(osp, 8'hff);
		chk(ram[255], 8'h5a);
		cmd(OP_LOAD_X, 8'ha5);
		chk(idx, 8'ha5);
		cmd(OP_PUSH_X);
		chk({osp, ram[254]}, 16'hfea5);
		cmd(OP_LOAD_A, 8'h00);
		cmd(OP_POP_A);
		chk(acc, 8'ha5);
		cmd(OP_POP_X);
		chk({idx, osp}, 16'h5a00);
	endtask
	task automatic t_modes();
		cmd(OP_LOAD_X, 8'hf3);
		cmd(OP_LOAD_A, 8'h3c);
		cmd(OP_STORE_A, 8'h03, MODE_DIR);
		chk(ram[3], 8'h3c);
		cmd(OP_LOAD_A, 8'hc3);
		cmd(OP_STORE_A, 8'h4d, MODE_INDEX);
		cmd(OP_STORE_A, 8'h03, MODE_IMM);
		chk({ram[3], ram[64]}, 16'h3cc3);
		cmd(OP_LOAD_A, 8'h10, MODE_INDEX);
		chk(acc, 8'h3c);
		cmd(OP_LOAD_A, 8'h40, MODE_DIR);
		chk(acc, 8'hc3);
		cmd(OP_LOAD_X, 8'h03, MODE_DIR);
		chk(idx, 8'h3c);
		cmd(OP_SWAP_AX);
		chk({acc, idx}, 16'h3cc3);
	endtask
	task automatic t_return();
		cmd(OP_LOAD_A, 8'h10);
		cmd(OP_RSP_A);
		chk(rsp, 8'h10);
		cmd(OP_FLAGS, 8'h03);
		cmd(OP_CALL, 8'h00, MODE_IMM, 14'h2345);
		chk(ip, 14'h2345);
		chk(rsp, 8'h12);
		chk({ram[16], ram[17]}, 16'hc100);
		cmd(OP_FLAGS);
		cmd(OP_SRET);
		chk(ip, 14'h0100);
		chk({cf, zf, rsp}, 10'h010);
		cmd(OP_FLAGS, 8'h02);
		cmd(OP_INTR, 8'h00, MODE_IMM, 14'h0004);
		chk({ie, ram[16]}, 9'h081);
		cmd(OP_FLAGS);
		cmd(OP_IRET);
		chk(ip, 14'h0100);
		chk({cf, zf, ie, rsp}, 11'h510);
		cmd(OP_INTR, 8'h00, MODE_IMM, 14'h0004);
		chk(ie, 1'b0);
	endtask
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_FLAGS;
		cmd_mode = MODE_IMM;
		cmd_operand = 8'h00;
		cmd_target = 14'h0000;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_pointer();
		t_stack();
		t_modes();
		t_return();
		conclude();
	end
endmodule
